// ---- src/pfm_port_pin_function_mux.sv ----
// Functional notes
// - p1.0 selected outputs converter clock; input feeds timer external clock; software direction.
// - p1.1-p1.3 selected drive timer outputs 0-2; inputs feed capture inputs 0A-2A.
// - p1.4 selected outputs sub-main system clock; input goes nowhere.
// - p1.5-p1.7 selected drive timer outputs 0-2; no peripheral input.
// - p2.0 selected outputs auxiliary clock; input goes nowhere.
// - p2.1 selected drives low; input feeds timer alternate clock.
// - p2.2 selected drives timer output 0; input feeds capture input 0B.
// - p2.3 drives timer output 1, feeds capture 1B; p2.4 drives timer output 2.
// - p2.5 peripheral output low, input nowhere; pin shares oscillator resistor function.
// - p2.6/p2.7 have no pins, full control bits, flags changed only by software.
// - each port 1/2 bit has enable, flag and edge select bits.
// - p3.0 selected forces input, drives low; input feeds slave transmit enable.
// - p3.6/p3.7 peripheral output low, no input destination, software direction.
// - p3.4 selected forces output and drives serial transmit line.
// - p3.5 selected forces input and feeds serial receive line.
// - p3.3 selected in asynchronous mode is always an input.
// - synchronous slave mode takes the shift clock from the serial clock pin.
// - synchronous master mode drives the shift clock out on the serial clock pin.
`timescale 1ns/100ps
module pfm_port_pin_function_mux
  import pfm_pkg::*;
(
  input wire logic sys_clk, // 50 MHz system clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [7:0] p1PinFunctionSelect, // port 1 peripheral select
  input wire logic [7:0] p1PinDirection, // port 1 direction, 1 = output
  input wire logic [7:0] p1PinOutputValue, // port 1 output register
  input wire logic [7:0] p1PinInterruptEnable, // port 1 interrupt enables
  input wire logic [7:0] p1PinEdgeSelect, // port 1 edge selects
  input wire logic p1FlagWriteEn, // port 1 flag write strobe
  input wire logic [7:0] p1FlagWriteData, // port 1 flag write value
  input wire logic [7:0] p2PinFunctionSelect, // port 2 peripheral select
  input wire logic [7:0] p2PinDirection, // port 2 direction
  input wire logic [7:0] p2PinOutputValue, // port 2 output register
  input wire logic [7:0] p2PinInterruptEnable, // port 2 interrupt enables
  input wire logic [7:0] p2PinEdgeSelect, // port 2 edge selects
  input wire logic p2FlagWriteEn, // port 2 flag write strobe
  input wire logic [7:0] p2FlagWriteData, // port 2 flag write value
  input wire logic [7:0] p3PinFunctionSelect, // port 3 peripheral select
  input wire logic [7:0] p3PinDirection, // port 3 direction
  input wire logic [7:0] p3PinOutputValue, // port 3 output register
  output logic [7:0] p1PinInputValue, // port 1 synchronised inputs
  output logic [7:0] p1PinInterruptFlag, // port 1 interrupt flags
  output logic [7:0] p2PinInputValue, // port 2 synchronised inputs
  output logic [7:0] p2PinInterruptFlag, // port 2 interrupt flags
  output logic [7:0] p3PinInputValue, // port 3 synchronised inputs
  output logic p1InterruptRequest, // any enabled port 1 flag
  output logic p2InterruptRequest, // any enabled port 2 flag
  input wire logic [7:0] p1PadIn, // port 1 pad level
  output logic [7:0] p1PadOut, // port 1 pad drive value
  output logic [7:0] p1PadOeN, // port 1 pad enable, low drives
  input wire logic [5:0] p2PadIn, // port 2 pad level
  output logic [5:0] p2PadOut, // port 2 pad drive value
  output logic [5:0] p2PadOeN, // port 2 pad enable, low drives
  input wire logic [7:0] p3PadIn, // port 3 pad level
  output logic [7:0] p3PadOut, // port 3 pad drive value
  output logic [7:0] p3PadOeN, // port 3 pad enable, low drives
  input wire logic converterClock, // converter clock
  input wire logic subMainSystemClock, // sub-main system clock
  input wire logic auxiliaryClock, // auxiliary clock
  input wire logic timerOutputZero, // timer output 0
  input wire logic timerOutputOne, // timer output 1
  input wire logic timerOutputTwo, // timer output 2
  output logic timerExternalClock, // timer external clock in
  output logic timerAlternateClock, // timer alternate clock in
  output logic captureInputZeroA, // capture input 0A
  output logic captureInputOneA, // capture input 1A
  output logic captureInputTwoA, // capture input 2A
  output logic captureInputZeroB, // capture input 0B
  output logic captureInputOneB, // capture input 1B
  input wire logic serialSyncMode, // serial unit synchronous mode
  input wire logic serialMasterMode, // serial unit master mode
  input wire logic serialTransmitLine, // serial transmit data
  input wire logic serialMasterOutData, // serial master data out
  input wire logic serialSlaveOutData, // serial slave data out
  input wire logic serialClockOut, // serial shift clock from unit
  output logic serialReceiveLine, // serial receive data
  output logic serialMasterInData, // serial data from p3.1
  output logic serialSlaveInData, // serial data from p3.2
  output logic serialClockIn, // serial shift clock to unit
  output logic serialSlaveTransmitEnable // serial slave transmit enable
);

  // ==========================================================
  // gathering of port vectors
  logic [7:0] selA [PORT_COUNT];
  logic [7:0] dirA [PORT_COUNT];
  logic [7:0] outA [PORT_COUNT];
  logic [7:0] padInA [PORT_COUNT];
  logic [7:0] modOut [PORT_COUNT];
  logic [7:0] dirEff [PORT_COUNT];
  logic [7:0] pinMask [PORT_COUNT];
  logic [7:0] padOut_reg [PORT_COUNT];
  logic [7:0] padOut_next [PORT_COUNT];
  logic [7:0] padOeN_reg [PORT_COUNT];
  logic [7:0] padOeN_next [PORT_COUNT];
  logic [7:0] syncA_reg [PORT_COUNT];
  logic [7:0] in_reg [PORT_COUNT];
  logic [7:0] prevIn_reg [PORT_COUNT];
  logic [7:0] p1Flag_reg;
  logic [7:0] p1Flag_next;
  logic [7:0] p2Flag_reg;
  logic [7:0] p2Flag_next;

  assign selA[PORT1_IDX] = p1PinFunctionSelect;
  assign selA[PORT2_IDX] = p2PinFunctionSelect;
  assign selA[PORT3_IDX] = p3PinFunctionSelect;
  assign dirA[PORT1_IDX] = p1PinDirection;
  assign dirA[PORT2_IDX] = p2PinDirection;
  assign dirA[PORT3_IDX] = p3PinDirection;
  assign outA[PORT1_IDX] = p1PinOutputValue;
  assign outA[PORT2_IDX] = p2PinOutputValue;
  assign outA[PORT3_IDX] = p3PinOutputValue;
  assign padInA[PORT1_IDX] = p1PadIn;
  assign padInA[PORT2_IDX] = {2'h0, p2PadIn};
  assign padInA[PORT3_IDX] = p3PadIn;
  assign pinMask[PORT1_IDX] = P1_PIN_MASK;
  assign pinMask[PORT2_IDX] = P2_PIN_MASK;
  assign pinMask[PORT3_IDX] = P3_PIN_MASK;

  // ==========================================================
  // peripheral output and direction selection
  always_comb begin
    modOut[PORT1_IDX] = {timerOutputTwo, timerOutputOne, timerOutputZero, subMainSystemClock,
                         timerOutputTwo, timerOutputOne, timerOutputZero, converterClock};
    // p2.1 and p2.5 drive low; p2.5 analog resistor path lives outside this logic
    modOut[PORT2_IDX] = {3'h0, timerOutputTwo, timerOutputOne, timerOutputZero, 1'h0, auxiliaryClock};
    modOut[PORT3_IDX] = {3'h0, serialTransmitLine, serialClockOut, serialSlaveOutData, serialMasterOutData, 1'h0};
    dirEff[PORT1_IDX] = dirA[PORT1_IDX];
    dirEff[PORT2_IDX] = dirA[PORT2_IDX];
    dirEff[PORT3_IDX] = dirA[PORT3_IDX];
    if (selA[PORT3_IDX][P3_STE_BIT]) begin
      dirEff[PORT3_IDX][P3_STE_BIT] = 1'h0;
    end
    if (selA[PORT3_IDX][P3_TX_BIT]) begin
      dirEff[PORT3_IDX][P3_TX_BIT] = 1'h1;
    end
    if (selA[PORT3_IDX][P3_RX_BIT]) begin
      dirEff[PORT3_IDX][P3_RX_BIT] = 1'h0;
    end
    if (selA[PORT3_IDX][P3_CLK_BIT]) begin
      // clock pin direction follows the serial unit's mode
      dirEff[PORT3_IDX][P3_CLK_BIT] = serialSyncMode & serialMasterMode;
    end
    for (int p = 0; p < PORT_COUNT; p++) begin
      padOut_next[p] = (selA[p] & modOut[p]) | (~selA[p] & outA[p]);
      padOeN_next[p] = ~dirEff[p];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        padOut_reg[p] <= CTRL_RESET;
        padOeN_reg[p] <= OE_N_RESET;
      end
    end else begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        padOut_reg[p] <= padOut_next[p];
        padOeN_reg[p] <= padOeN_next[p];
      end
    end
  end

  // ==========================================================
  // input synchroniser and edge history
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        syncA_reg[p] <= CTRL_RESET;
        in_reg[p] <= CTRL_RESET;
        prevIn_reg[p] <= CTRL_RESET;
      end
    end else begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        syncA_reg[p] <= padInA[p] & pinMask[p];
        in_reg[p] <= syncA_reg[p];
        prevIn_reg[p] <= in_reg[p];
      end
    end
  end

  // ==========================================================
  // interrupt flags; a hardware edge wins over a software clear
  always_comb begin
    p1Flag_next = (p1FlagWriteEn ? p1FlagWriteData : p1Flag_reg) |
                  pfmEdge(in_reg[PORT1_IDX], prevIn_reg[PORT1_IDX], p1PinEdgeSelect);
    // unbonded bits never see an edge, so only writes move them
    p2Flag_next = (p2FlagWriteEn ? p2FlagWriteData : p2Flag_reg) |
                  (pfmEdge(in_reg[PORT2_IDX], prevIn_reg[PORT2_IDX], p2PinEdgeSelect) & P2_PIN_MASK);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      p1Flag_reg <= FLAG_RESET;
      p2Flag_reg <= FLAG_RESET;
    end else begin
      p1Flag_reg <= p1Flag_next;
      p2Flag_reg <= p2Flag_next;
    end
  end

  // ==========================================================
  // outputs
  assign p1PinInputValue = in_reg[PORT1_IDX];
  assign p2PinInputValue = in_reg[PORT2_IDX];
  assign p3PinInputValue = in_reg[PORT3_IDX];
  assign p1PinInterruptFlag = p1Flag_reg;
  assign p2PinInterruptFlag = p2Flag_reg;
  assign p1InterruptRequest = |(p1Flag_reg & p1PinInterruptEnable);
  assign p2InterruptRequest = |(p2Flag_reg & p2PinInterruptEnable);
  assign p1PadOut = padOut_reg[PORT1_IDX];
  assign p1PadOeN = padOeN_reg[PORT1_IDX];
  assign p2PadOut = padOut_reg[PORT2_IDX][5:0];
  assign p2PadOeN = padOeN_reg[PORT2_IDX][5:0];
  assign p3PadOut = padOut_reg[PORT3_IDX];
  assign p3PadOeN = padOeN_reg[PORT3_IDX];

  // peripheral inputs read low while their pin is in port mode
  assign timerExternalClock = selA[PORT1_IDX][P1_CONV_CLK_BIT] & in_reg[PORT1_IDX][P1_CONV_CLK_BIT];
  assign captureInputZeroA = selA[PORT1_IDX][P1_CAP_ZERO_A_BIT] & in_reg[PORT1_IDX][P1_CAP_ZERO_A_BIT];
  assign captureInputOneA = selA[PORT1_IDX][P1_CAP_ONE_A_BIT] & in_reg[PORT1_IDX][P1_CAP_ONE_A_BIT];
  assign captureInputTwoA = selA[PORT1_IDX][P1_CAP_TWO_A_BIT] & in_reg[PORT1_IDX][P1_CAP_TWO_A_BIT];
  assign timerAlternateClock = selA[PORT2_IDX][P2_ALT_CLK_BIT] & in_reg[PORT2_IDX][P2_ALT_CLK_BIT];
  assign captureInputZeroB = selA[PORT2_IDX][P2_CAP_ZERO_B_BIT] & in_reg[PORT2_IDX][P2_CAP_ZERO_B_BIT];
  assign captureInputOneB = selA[PORT2_IDX][P2_CAP_ONE_B_BIT] & in_reg[PORT2_IDX][P2_CAP_ONE_B_BIT];
  assign serialSlaveTransmitEnable = selA[PORT3_IDX][P3_STE_BIT] & in_reg[PORT3_IDX][P3_STE_BIT];
  assign serialMasterInData = selA[PORT3_IDX][P3_MO_BIT] & in_reg[PORT3_IDX][P3_MO_BIT];
  assign serialSlaveInData = selA[PORT3_IDX][P3_SO_BIT] & in_reg[PORT3_IDX][P3_SO_BIT];
  assign serialClockIn = selA[PORT3_IDX][P3_CLK_BIT] & in_reg[PORT3_IDX][P3_CLK_BIT];
  assign serialReceiveLine = selA[PORT3_IDX][P3_RX_BIT] & in_reg[PORT3_IDX][P3_RX_BIT];

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_P1_CONV_CLK: assert property (p1PinFunctionSelect[0] |=> p1PadOut[0] == $past(converterClock))
    else $error("p1.0 does not carry converter clock");
  AST_P1_CAPTURE: assert property (p1PinFunctionSelect[2] && $rose(p1PinInputValue[2]) |-> captureInputOneA)
    else $error("capture input 1A misses p1.2");
  AST_P1_SUBMAIN: assert property (p1PinFunctionSelect[4] |=> p1PadOut[4] == $past(subMainSystemClock))
    else $error("p1.4 does not carry sub-main clock");
  AST_P1_TIMER_HI: assert property (p1PinFunctionSelect[7] |=> p1PadOut[7] == $past(timerOutputTwo))
    else $error("p1.7 does not carry timer output 2");
  AST_P2_AUX: assert property (p2PinFunctionSelect[0] |=> p2PadOut[0] == $past(auxiliaryClock))
    else $error("p2.0 does not carry auxiliary clock");
  AST_P2_LOW: assert property (p2PinFunctionSelect[1] ##1 p2PinFunctionSelect[1] |=> !p2PadOut[1])
    else $error("p2.1 peripheral output not low");
  AST_P2_CAP_B: assert property (p2PinFunctionSelect[2] |-> captureInputZeroB == p2PinInputValue[2])
    else $error("capture input 0B differs from p2.2");
  AST_P2_TIMER_ONE: assert property (p2PinFunctionSelect[3] |=> p2PadOut[3] == $past(timerOutputOne))
    else $error("p2.3 does not carry timer output 1");
  AST_P2_OSC_LOW: assert property (p2PinFunctionSelect[5] |=> !p2PadOut[5])
    else $error("p2.5 peripheral output not low");
  AST_SOFT_FLAGS: assert property (!p2FlagWriteEn |=> $stable(p2PinInterruptFlag[7:6]))
    else $error("unbonded flag changed without a write");
  AST_EDGE_FLAG: assert property (!p1PinEdgeSelect[0] && $rose(p1PinInputValue[0]) |=> p1PinInterruptFlag[0])
    else $error("rising edge did not set p1.0 flag");
  AST_P3_STE: assert property (p3PinFunctionSelect[0] |=> p3PadOeN[0] && !p3PadOut[0])
    else $error("p3.0 not forced to input");
  AST_P3_SPARE: assert property (p3PinFunctionSelect[6] |=> !p3PadOut[6] && p3PadOeN[6] == !$past(p3PinDirection[6]))
    else $error("p3.6 peripheral behaviour wrong");
  AST_P3_TX: assert property (p3PinFunctionSelect[4] |=> !p3PadOeN[4] && p3PadOut[4] == $past(serialTransmitLine))
    else $error("p3.4 not driving transmit line");
  AST_P3_RX: assert property (p3PinFunctionSelect[5] |=> p3PadOeN[5])
    else $error("p3.5 not forced to input");
  AST_P3_UART_CLK: assert property (p3PinFunctionSelect[3] && !serialSyncMode |=> p3PadOeN[3])
    else $error("serial clock pin drives in asynchronous mode");
  AST_P3_SLAVE_CLK: assert property (p3PinFunctionSelect[3] && serialSyncMode && !serialMasterMode
                                     |-> serialClockIn == p3PinInputValue[3] ##1 p3PadOeN[3])
    else $error("slave clock not taken from pin");
  AST_P3_MASTER_CLK: assert property (p3PinFunctionSelect[3] && serialSyncMode && serialMasterMode
                                      |=> !p3PadOeN[3] && p3PadOut[3] == $past(serialClockOut))
    else $error("master clock not driven on pin");
  AST_PLAIN_PORT: assert property (!p1PinFunctionSelect[6] |=> p1PadOut[6] == $past(p1PinOutputValue[6]) &&
                                   p1PadOeN[6] == !$past(p1PinDirection[6]))
    else $error("p1.6 plain port behaviour wrong");
  AST_P1_CONV_DIR: assert property (p1PinFunctionSelect[0] |=> p1PadOeN[0] == !$past(p1PinDirection[0]))
    else $error("p1.0 direction not under software");
  AST_P1_TIMER_LO: assert property (p1PinFunctionSelect[1] |=> p1PadOut[1] == $past(timerOutputZero))
    else $error("p1.1 does not carry timer output 0");
  AST_P1_TIMER_MID: assert property (p1PinFunctionSelect[5] |=> p1PadOut[5] == $past(timerOutputZero))
    else $error("p1.5 does not carry timer output 0");
  AST_P2_ALT_CLK: assert property (p2PinFunctionSelect[1] |-> timerAlternateClock == p2PinInputValue[1])
    else $error("timer alternate clock differs from p2.1");
  AST_P2_TIMER_ZERO: assert property (p2PinFunctionSelect[2] |=> p2PadOut[2] == $past(timerOutputZero))
    else $error("p2.2 does not carry timer output 0");
  AST_P2_TIMER_TWO: assert property (p2PinFunctionSelect[4] |=> p2PadOut[4] == $past(timerOutputTwo))
    else $error("p2.4 does not carry timer output 2");
  AST_UNBONDED_IN: assert property (p2PinInputValue[7:6] == 2'h0)
    else $error("unbonded p2 bits read high");
  AST_FLAG_STICKY: assert property (!p1FlagWriteEn && p1PinInterruptFlag[0] |=> p1PinInterruptFlag[0])
    else $error("p1.0 flag dropped without a write");
  AST_P3_STE_IN: assert property (p3PinFunctionSelect[0] |->
                                  serialSlaveTransmitEnable == p3PinInputValue[0])
    else $error("slave transmit enable differs from p3.0");
  AST_P3_SPARE_HI: assert property (p3PinFunctionSelect[7] |=> !p3PadOut[7] &&
                                    p3PadOeN[7] == !$past(p3PinDirection[7]))
    else $error("p3.7 peripheral behaviour wrong");
  AST_P3_RX_IN: assert property (p3PinFunctionSelect[5] |-> serialReceiveLine == p3PinInputValue[5])
    else $error("serial receive line differs from p3.5");
  AST_PLAIN_P3: assert property (!p3PinFunctionSelect[4] |=> p3PadOut[4] == $past(p3PinOutputValue[4]) &&
                                 p3PadOeN[4] == !$past(p3PinDirection[4]))
    else $error("p3.4 plain port behaviour wrong");

endmodule : pfm_port_pin_function_mux

// ---- src/pfm_pkg.sv ----
// ==========================================================
// shared constants of the pin function multiplexer
package pfm_pkg;
  localparam int PORT_WIDTH = 8;
  localparam int PORT_COUNT = 3;
  localparam int P2_BONDED_PINS = 6;

  // port indices inside the unpacked arrays
  localparam int PORT1_IDX = 0;
  localparam int PORT2_IDX = 1;
  localparam int PORT3_IDX = 2;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] OE_N_RESET = 8'hFF;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // bits that have a physical pin, per port
  localparam logic [7:0] P1_PIN_MASK = 8'hFF;
  localparam logic [7:0] P2_PIN_MASK = 8'h3F;
  localparam logic [7:0] P3_PIN_MASK = 8'hFF;

  // bit positions of special functions
  localparam int P1_CONV_CLK_BIT = 0;
  localparam int P1_CAP_ZERO_A_BIT = 1;
  localparam int P1_CAP_ONE_A_BIT = 2;
  localparam int P1_CAP_TWO_A_BIT = 3;
  localparam int P1_SUBMAIN_BIT = 4;
  localparam int P2_AUX_CLK_BIT = 0;
  localparam int P2_ALT_CLK_BIT = 1;
  localparam int P2_CAP_ZERO_B_BIT = 2;
  localparam int P2_CAP_ONE_B_BIT = 3;
  localparam int P2_OSC_RES_BIT = 5;
  localparam int P3_STE_BIT = 0;
  localparam int P3_MO_BIT = 1;
  localparam int P3_SO_BIT = 2;
  localparam int P3_CLK_BIT = 3;
  localparam int P3_TX_BIT = 4;
  localparam int P3_RX_BIT = 5;

  // edge select 0: low-to-high, 1: high-to-low
  function automatic logic [7:0] pfmEdge(input logic [7:0] cur, input logic [7:0] prev, input logic [7:0] ies);
    pfmEdge = (~ies & cur & ~prev) | (ies & ~cur & prev);
  endfunction : pfmEdge
endpackage : pfm_pkg

// ---- dv/pfm_periph_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// peripheral side: timer, converter, clock and serial unit levels
module pfm_periph_model
  import pfm_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic [11:0] drive, // levels requested by the bench
  output logic converterClock, // converter clock
  output logic subMainSystemClock, // sub-main system clock
  output logic auxiliaryClock, // auxiliary clock
  output logic timerOutputZero, // timer output 0
  output logic timerOutputOne, // timer output 1
  output logic timerOutputTwo, // timer output 2
  output logic serialTransmitLine, // serial transmit data
  output logic serialMasterOutData, // serial master data out
  output logic serialSlaveOutData, // serial slave data out
  output logic serialClockOut, // serial shift clock
  output logic serialSyncMode, // synchronous mode
  output logic serialMasterMode // master mode
);
  logic [11:0] level_reg;
  logic [11:0] level_next;

  always_comb begin
    level_next = drive;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= 12'h000;
    end else begin
      level_reg <= level_next;
    end
  end

  // shift clock and data are offered to the pins only as levels
  assign {serialMasterMode, serialSyncMode, serialClockOut, serialSlaveOutData, serialMasterOutData} = level_reg[11:7];
  assign {serialTransmitLine, timerOutputTwo, timerOutputOne, timerOutputZero} = level_reg[6:3];
  assign {auxiliaryClock, subMainSystemClock, converterClock} = level_reg[2:0];
endmodule : pfm_periph_model

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
// ==========================================================
// bench for the pin function multiplexer
module tb_top;
  import pfm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] p1PinFunctionSelect = '0, p1PinDirection = '0, p1PinOutputValue = '0, p1PinInterruptEnable = '0;
  logic [7:0] p1PinEdgeSelect = '0, p1FlagWriteData = '0, p2PinFunctionSelect = '0, p2PinDirection = '0;
  logic [7:0] p2PinOutputValue = '0, p2PinInterruptEnable = '0, p2PinEdgeSelect = '0, p2FlagWriteData = '0;
  logic [7:0] p3PinFunctionSelect = '0, p3PinDirection = '0, p3PinOutputValue = '0, p1PadIn = '0, p3PadIn = '0;
  logic [5:0] p2PadIn = '0;
  logic p1FlagWriteEn = 1'b0, p2FlagWriteEn = 1'b0;
  logic [11:0] drive = '0;
  logic [7:0] p1PinInputValue, p1PinInterruptFlag, p2PinInputValue, p2PinInterruptFlag, p3PinInputValue;
  logic [7:0] p1PadOut, p1PadOeN, p3PadOut, p3PadOeN;
  logic [5:0] p2PadOut, p2PadOeN;
  logic p1InterruptRequest, p2InterruptRequest, converterClock, subMainSystemClock, auxiliaryClock;
  logic timerOutputZero, timerOutputOne, timerOutputTwo, timerExternalClock, timerAlternateClock;
  logic captureInputZeroA, captureInputOneA, captureInputTwoA, captureInputZeroB, captureInputOneB;
  logic serialSyncMode, serialMasterMode, serialTransmitLine, serialMasterOutData, serialSlaveOutData;
  logic serialClockOut, serialReceiveLine, serialMasterInData, serialSlaveInData, serialClockIn;
  logic serialSlaveTransmitEnable;
  logic [11:0] d;
  logic [7:0] dr, pa;
  int mismatches = 0;
  int n_tests = 0;
  wire [7:0] timerIns = {1'b0, timerExternalClock, timerAlternateClock, captureInputZeroA, captureInputOneA,
    captureInputTwoA, captureInputZeroB, captureInputOneB};
  wire [7:0] serialIns = {3'h0, serialReceiveLine, serialMasterInData, serialSlaveInData, serialClockIn,
    serialSlaveTransmitEnable};

  always #10 sys_clk = ~sys_clk;

  pfm_port_pin_function_mux dut (.*);
  pfm_periph_model model (.*);

  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic settle();
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  task automatic write_flags(input logic [7:0] a, input logic [7:0] b);
    @(posedge sys_clk);
    {p1FlagWriteEn, p1FlagWriteData, p2FlagWriteEn, p2FlagWriteData} <= {1'b1, a, 1'b1, b};
    @(posedge sys_clk);
    {p1FlagWriteEn, p2FlagWriteEn} <= 2'b00;
    settle();
  endtask : write_flags

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================
  // tests
  initial begin
    repeat (8) @(posedge sys_clk);
    chk(p1PadOeN, 8'hFF, "reset drive");
    rst_n <= 1'b1;
    // plain port while every peripheral level is high
    @(posedge sys_clk);
    {p1PinDirection, p1PinOutputValue, p2PinDirection, p2PinOutputValue} <= {8'hFF, 8'hA5, 8'h3C, 8'h15};
    {p3PinDirection, p3PinOutputValue, p1PadIn, p3PadIn, p2PadIn} <= {8'h0F, 8'h5A, 8'h3C, 8'hC3, 6'h2A};
    drive <= 12'hFFF;
    settle();
    chk(p1PadOut, 8'hA5, "p1 plain out");
    chk(p1PadOeN, 8'h00, "p1 plain dir");
    chk({2'h0, p2PadOut}, 8'h15, "p2 plain out");
    chk({2'h0, p2PadOeN}, 8'h03, "p2 plain dir");
    chk(p3PadOut, 8'h5A, "p3 plain out");
    chk(p3PadOeN, 8'hF0, "p3 plain dir");
    chk(p1PinInputValue, 8'h3C, "p1 in");
    chk(p2PinInputValue, 8'h2A, "p2 in");
    chk(p3PinInputValue, 8'hC3, "p3 in");
    chk(timerIns | serialIns, 8'h00, "idle periph ins");
    // peripheral mode, every serial mode pairing, two level patterns
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      d = {k[1:0], k[0] ? 10'h2A5 : 10'h15A};
      dr = k[1] ? 8'hC3 : 8'h3C;
      pa = k[0] ? 8'hA5 : 8'h5A;
      {p1PinFunctionSelect, p2PinFunctionSelect, p3PinFunctionSelect} <= 24'hFFFFFF;
      {p1PinDirection, p2PinDirection, p3PinDirection, drive} <= {dr, dr, dr, d};
      {p1PadIn, p2PadIn, p3PadIn} <= {pa, ~pa[5:0], ~pa};
      settle();
      chk(p1PadOut, {d[5:3], d[1], d[5:3], d[0]}, "p1 fn out");
      chk(p1PadOeN, ~dr, "p1 fn dir");
      chk({2'h0, p2PadOut}, {3'h0, d[5:3], 1'b0, d[2]}, "p2 fn out");
      chk({2'h0, p2PadOeN}, {2'h0, ~dr[5:0]}, "p2 fn dir");
      chk(p3PadOut, {3'h0, d[6], d[9], d[8], d[7], 1'b0}, "p3 fn out");
      chk(p3PadOeN, {~dr[7:6], 2'b10, ~(d[10] & d[11]), ~dr[2:1], 1'b1}, "p3 fn dir");
      chk(timerIns, {1'b0, pa[0], ~pa[1], pa[1], pa[2], pa[3], ~pa[2], ~pa[3]}, "timer ins");
      chk(serialIns, {3'h0, ~pa[5], ~pa[1], ~pa[2], ~pa[3], ~pa[0]}, "serial ins");
    end
    // edge flags for both edge selects, wrong edge ignored
    for (int e = 0; e < 2; e++) begin
      @(posedge sys_clk);
      pa = e ? 8'hFF : 8'h00;
      {p1PinFunctionSelect, p2PinFunctionSelect, p3PinFunctionSelect} <= 24'h000000;
      {p1PinEdgeSelect, p2PinEdgeSelect, p1PadIn, p2PadIn} <= {pa, pa, pa, pa[5:0]};
      {p1PinInterruptEnable, p2PinInterruptEnable} <= 16'h0810;
      settle();
      write_flags(8'h00, 8'h00);
      chk(p1PinInterruptFlag | p2PinInterruptFlag, 8'h00, "flags cleared");
      @(posedge sys_clk);
      {p1PadIn, p2PadIn} <= {pa ^ 8'h0F, pa[5:0] ^ 6'h0F};
      settle();
      chk(p1PinInterruptFlag, 8'h0F, "p1 flags");
      chk(p2PinInterruptFlag, 8'h0F, "p2 flags");
      chk({6'h0, p1InterruptRequest, p2InterruptRequest}, 8'h02, "requests");
      write_flags(8'h00, 8'h00);
      @(posedge sys_clk);
      {p1PadIn, p2PadIn} <= {pa, pa[5:0]};
      settle();
      chk(p1PinInterruptFlag | p2PinInterruptFlag, 8'h00, "wrong edge");
    end
    // flags without pins are set and cleared only by writes
    @(posedge sys_clk);
    p2PinInterruptEnable <= 8'h80;
    write_flags(8'h00, 8'hC0);
    chk(p2PinInterruptFlag, 8'hC0, "soft flags");
    chk({7'h0, p2InterruptRequest}, 8'h01, "soft request");
    @(posedge sys_clk);
    p2PadIn <= 6'h00;
    settle();
    chk(p2PinInterruptFlag & 8'hC0, 8'hC0, "soft flags kept");
    write_flags(8'h00, 8'h00);
    chk({5'h0, p2PinInterruptFlag[7:6], p2InterruptRequest}, 8'h00, "soft clear");
    give_verdict();
  end

  initial begin
    repeat (2000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end
endmodule : tb_top
